// *** design/mcbt_bus_seq.sv ***
// multi-cycle and burst transfer sequencer on the external bus
// Function
// RL1: prefetch, fp load, unaligned, fill may take multiple cycles
// RL2: burst items every clock, first needs two
// RL3: burst writes only on 8/16-bit bus, 32 bits
// RL4: burst starts with strobe, last deasserted second clock
// RL5: memory answers first cycle with burst ready to burst
// RL6: burst stays in one 16-byte line
// RL7: any multi-cycle read bursts only needed bytes; a cache fill with cache enable low bursts the whole 4-word line
// RL8: non-burstable cycles treat burst ready as ready
// RL9: both readies asserted: burst ready is ignored
// RL10: non-burst memories end cycles with nonburst ready
// RL11: last deasserted except in the final cycle
// RL12: memory ignores last in first clock
// RL13: cycle count from size, bus width, cache, alignment
// RL14: memory gives cache and size one clock early
// RL15: nonburst ready ends burst, rest follows burst order
// RL16: non-burst cycles each strobe and end on ready
// RL17: burst read strobes only in first cycle
// RL18: memory never asserts both readies in a burst
// RL19: bus cycle at least two clocks, strobe then ready
// RL20: any number of wait states accepted
// RL21: word order is first address xor item count
// RL22: handshakes active low, sampled on rising clock
`timescale 1ns/10ps
`default_nettype none
`include "mcbt_defines.svh"
module mcbt_bus_seq (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [31:0] req_addr,
  input wire logic [2:0] req_size,
  input wire logic req_write,
  input wire logic [31:0] req_wdata,
  input wire logic req_mem,
  input wire logic req_data,
  input wire logic req_burstable,
  input wire logic req_cacheable,
  output logic rd_valid,
  input wire logic rd_ready,
  output mcbt_pkg::mcbt_word_t rd_data,
  output logic addr_strobe_n,
  output logic last_transfer_n,
  output logic [27:0] line_address_upper,
  output logic [1:0] word_addr,
  output logic [3:0] byte_lane_enables_n,
  output logic mem_or_io_sel,
  output logic data_or_code_sel,
  output logic write_or_read_sel,
  output logic [31:0] data_out,
  output logic data_oe,
  input wire logic [31:0] data_in,
  input wire logic nonburst_ready_n,
  input wire logic burst_ready_n,
  input wire logic cache_enable_in_n,
  input wire logic bus_size8_n,
  input wire logic bus_size16_n
);
  import mcbt_pkg::*;

  typedef struct packed {
    mcbt_state_e st;
    logic ads_n;
    logic last_transfer_n_n;
    logic req_ready;
    logic [27:0] line;
    logic [1:0] first;
    logic [1:0] widx;
    logic [1:0] k;
    logic [1:0] sub;
    logic [2:0] nwords;
    logic [2:0] tot;
    logic fill_known;
    logic [7:0] mask;
    logic [3:0] be_n;
    logic mio;
    logic dc;
    logic wr;
    logic burstable;
    logic cacheable;
    logic ken_q_n;
    logic bs8_q_n;
    logic bus_size16_n_q_n;
    mcbt_word_t wdata;
    mcbt_word_t dout;
    logic doe;
    mcbt_word_t rbuf;
    logic push;
  } mcbt_seq_s;

  mcbt_seq_s s_r, s_nxt;
  logic fifo_in_ready;
  logic [`MCBT_CNT_W-1:0] fifo_cnt;
  logic room;
  logic nb, br, rdy, done, cont, lastsub;
  logic [2:0] subs_now, subs_q, tot_now, tot_q;
  logic [1:0] k_n, sub_n;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // data cycles per 32-bit word for a bus-size pair
  function automatic logic [2:0] subs_of(input logic b8_n,
                                         input logic b16_n);
    subs_of = !b8_n ? 3'h4 : (!b16_n ? 3'h2 : 3'h1);
  endfunction

  // true when item k, piece sub is the final data cycle
  function automatic logic is_last(input logic [1:0] k,
                                   input logic [1:0] sub,
                                   input logic [2:0] tot,
                                   input logic [2:0] subs);
    is_last = ({1'b0, k} == tot - 3'h1) &&
              ({1'b0, sub} == subs - 3'h1);
  endfunction

  // active-low lanes of word k from the request byte mask
  function automatic logic [3:0] lanes_n(input logic [7:0] mask,
                                         input logic [1:0] k,
                                         input logic fill);
    lanes_n = fill ? 4'h0 : (k[0] ? ~mask[7:4] : ~mask[3:0]);
  endfunction

  // merge one narrow or full data cycle into the word buffer
  function automatic mcbt_word_t merge(input mcbt_word_t buf_w,
                                       input mcbt_word_t din,
                                       input logic [2:0] subs,
                                       input logic [1:0] sub);
    mcbt_word_t r;
    r = buf_w;
    if (subs == 3'h4) r[sub*8 +: 8] = din[7:0];
    else if (subs == 3'h2) r[sub[0]*16 +: 16] = din[15:0];
    else r = din;
    merge = r;
  endfunction

  // a read may only start when a full line fits in the fifo; a word still
  // on its way into the fifo counts already, or a line could overflow it
  assign room = ((fifo_cnt + {5'h0, s_r.push}) <= `MCBT_ROOM_MAX) &&
                fifo_in_ready;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.push = 1'b0;
    // handshake inputs are plain levels taken at the rising edge [RL22]
    s_nxt.ken_q_n = cache_enable_in_n;
    s_nxt.bs8_q_n = bus_size8_n;
    s_nxt.bus_size16_n_q_n = bus_size16_n;
    subs_now = subs_of(bus_size8_n, bus_size16_n);
    subs_q = subs_of(s_r.bs8_q_n, s_r.bus_size16_n_q_n);
    // fill and length known from inputs of the clock before ready [RL13]
    tot_now = s_r.fill_known ? s_r.tot :
              ((s_r.cacheable && !s_r.wr && s_r.mio && !cache_enable_in_n)
               ? `MCBT_LINE_WORDS : s_r.nwords);
    tot_q = s_r.fill_known ? s_r.tot :
            ((s_r.cacheable && !s_r.wr && s_r.mio && !s_r.ken_q_n)
             ? `MCBT_LINE_WORDS : s_r.nwords);
    // nonburst ready wins when both are low [RL9]
    nb = !nonburst_ready_n;
    br = !burst_ready_n && nonburst_ready_n;
    rdy = nb || br;
    lastsub = ({1'b0, s_r.sub} == subs_q - 3'h1);
    done = lastsub && ({1'b0, s_r.k} == tot_q - 3'h1);
    // burst only where allowed; writes burst only on a narrow bus
    cont = br && s_r.burstable && (!s_r.wr || subs_q != 3'h1); // [RL8] [RL3]
    k_n = lastsub ? s_r.k + 2'h1 : s_r.k;
    sub_n = lastsub ? 2'h0 : s_r.sub + 2'h1;
    case (s_r.st)
      MCBT_IDLE: begin
        s_nxt.ads_n = 1'b1;
        s_nxt.doe = 1'b0;
        s_nxt.req_ready = room;
        if (req_valid && s_r.req_ready) begin
          // every request starts like a single cycle [RL4] [RL19]
          s_nxt.st = MCBT_T1;
          s_nxt.ads_n = 1'b0;
          s_nxt.req_ready = 1'b0;
          s_nxt.line = req_addr[31:`MCBT_LINE_LSB]; // [RL6]
          s_nxt.first = req_addr[3:`MCBT_WORD_LSB];
          s_nxt.widx = req_addr[3:`MCBT_WORD_LSB];
          s_nxt.k = 2'h0;
          s_nxt.sub = 2'h0;
          s_nxt.fill_known = 1'b0;
          // word count from size and alignment [RL1] [RL13] [RL7]
          case (req_size)
            `MCBT_SZ_16: s_nxt.nwords = 3'h4;
            `MCBT_SZ_8: s_nxt.nwords = 3'h2;
            default: s_nxt.nwords = ({1'b0, req_addr[1:0]} +
                                     (3'h1 << req_size) > 3'h4)
                                    ? 3'h2 : 3'h1;
          endcase
          s_nxt.tot = s_nxt.nwords;
          s_nxt.mask = (req_size > `MCBT_SZ_4) ? 8'hff :
                       8'((8'h01 << (3'h1 << req_size)) - 8'h01)
                       << req_addr[1:0];
          s_nxt.be_n = (req_size > `MCBT_SZ_4) ? 4'h0 :
                       ~s_nxt.mask[3:0];
          s_nxt.mio = req_mem;
          s_nxt.dc = req_data;
          s_nxt.wr = req_write;
          s_nxt.burstable = req_burstable;
          s_nxt.cacheable = req_cacheable;
          s_nxt.wdata = req_wdata;
          s_nxt.dout = req_wdata;
          s_nxt.doe = req_write;
        end
      end
      MCBT_T1: begin
        // ready in the first clock is not looked at
        s_nxt.ads_n = 1'b1;
        s_nxt.st = MCBT_T2;
        // more cycles to come keeps last high in the second clock [RL4]
        s_nxt.last_transfer_n_n = !is_last(s_r.k, s_r.sub, tot_now, subs_now);
      end
      MCBT_T2: begin
        if (rdy) begin
          s_nxt.fill_known = 1'b1;
          s_nxt.tot = tot_q;
          if (!s_r.wr) begin
            s_nxt.rbuf = merge(s_r.rbuf, data_in, subs_q, s_r.sub);
            s_nxt.push = lastsub;
          end
          if (done) begin
            s_nxt.st = MCBT_IDLE;
            s_nxt.last_transfer_n_n = 1'b1;
            s_nxt.doe = 1'b0;
          end else begin
            s_nxt.k = k_n;
            s_nxt.sub = sub_n;
            // next word follows the line order [RL21] [RL15]
            s_nxt.widx = s_r.first ^ k_n;
            s_nxt.be_n = lanes_n(s_r.mask, k_n,
                                 tot_q == `MCBT_LINE_WORDS);
            // narrow writes move the next piece to the low lanes
            s_nxt.dout = s_r.wdata >> ({3'h0, sub_n} *
                         ((subs_q == 3'h4) ? 5'h08 : 5'h10));
            if (cont) begin
              // next burst item without a new strobe [RL17] [RL2]
              s_nxt.last_transfer_n_n = !is_last(k_n, sub_n, tot_q, subs_now);
            end else begin
              // cut-short burst or non-burst: new strobed cycle [RL16] [RL15]
              s_nxt.st = MCBT_T1;
              s_nxt.ads_n = 1'b0;
            end
          end
        end else begin
          // wait state: hold address, keep last current [RL20] [RL11]
          s_nxt.last_transfer_n_n = !is_last(s_r.k, s_r.sub, tot_now, subs_now);
        end
      end
      default: begin
        s_nxt.st = MCBT_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
      s_r.st <= MCBT_IDLE;
      s_r.ads_n <= 1'b1;
      s_r.last_transfer_n_n <= 1'b1;
      s_r.be_n <= 4'hf;
      s_r.ken_q_n <= 1'b1;
      s_r.bs8_q_n <= 1'b1;
      s_r.bus_size16_n_q_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read-data fifo
  // ----------------------------------------------------------------
  // the user side can stall; starts are held off until a line fits
  mcbt_fifo #(
    .WIDTH(`MCBT_DATA_W),
    .DEPTH(`MCBT_FIFO_DEPTH),
    .CW(`MCBT_CNT_W)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(s_r.push),
    .in_ready(fifo_in_ready),
    .in_data(s_r.rbuf),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data),
    .count(fifo_cnt)
  );

  // bus outputs all come from the state register
  assign req_ready = s_r.req_ready;
  assign addr_strobe_n = s_r.ads_n;
  assign last_transfer_n = s_r.last_transfer_n_n;
  assign line_address_upper = s_r.line;
  assign word_addr = s_r.widx;
  assign byte_lane_enables_n = s_r.be_n;
  assign mem_or_io_sel = s_r.mio;
  assign data_or_code_sel = s_r.dc;
  assign write_or_read_sel = s_r.wr;
  assign data_out = s_r.dout;
  assign data_oe = s_r.doe;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence strobe_s;
    !addr_strobe_n;
  endsequence
  sequence second_clk_s;
    addr_strobe_n && s_r.st == MCBT_T2;
  endsequence

  strobe_two_clk_a: assert property (strobe_s |=> second_clk_s) // [RL19]
    else $error("strobe not followed by a second clock");
  line_stable_a: assert property (s_r.st == MCBT_T2 && // [RL6]
      $past(s_r.st) != MCBT_IDLE |-> $stable(line_address_upper) &&
      $stable({mem_or_io_sel, data_or_code_sel, write_or_read_sel}))
    else $error("line or cycle type changed inside a transfer");
  burst_no_strobe_a: assert property (s_r.st == MCBT_T2 && // [RL17]
      rdy && !done && cont |=> addr_strobe_n && s_r.st == MCBT_T2)
    else $error("burst item started with a strobe");
  nonburst_restrobe_a: assert property (s_r.st == MCBT_T2 && // [RL16]
      nb && !done |=> !addr_strobe_n ##1 addr_strobe_n)
    else $error("non-burst cycle not restarted with strobe");
  both_ready_a: assert property (s_r.st == MCBT_T2 && // [RL9]
      !nonburst_ready_n && !burst_ready_n |=> s_r.st != MCBT_T2)
    else $error("burst ready honoured with nonburst ready");
  no_burst_cyc_a: assert property (s_r.st == MCBT_T2 && br && // [RL8]
      !s_r.burstable |=> s_r.st != MCBT_T2)
    else $error("non-burstable cycle continued as burst");
  wide_write_a: assert property (s_r.st == MCBT_T2 && br && // [RL3]
      s_r.wr && subs_q == 3'h1 |=> s_r.st != MCBT_T2)
    else $error("32-bit write burst");
  wait_hold_a: assert property (s_r.st == MCBT_T2 && !rdy |=> // [RL20]
      s_r.st == MCBT_T2 && $stable(word_addr))
    else $error("wait state lost the cycle");
  word_order_a: assert property (s_r.st != MCBT_IDLE |-> // [RL21]
      word_addr == (s_r.first ^ s_r.k))
    else $error("word address out of line order");
  last_final_a: assert property (s_r.st == MCBT_T2 && rdy && // [RL11]
      done |-> !last_transfer_n)
    else $error("transfer ended without last asserted");
endmodule
`default_nettype wire

// *** design/mcbt_defines.svh ***
// constants for the multi-cycle burst bus sequencer
`ifndef MCBT_DEFINES_SVH
`define MCBT_DEFINES_SVH

// ----------------------------------------------------------------
// widths and sizes
// ----------------------------------------------------------------
`define MCBT_DATA_W 32
`define MCBT_FIFO_DEPTH 32
`define MCBT_CNT_W 6
`define MCBT_LINE_WORDS 3'h4
// a read may start only while the fifo can take a whole line
`define MCBT_ROOM_MAX 6'h1c

// ----------------------------------------------------------------
// request size codes (log2 of the byte count)
// ----------------------------------------------------------------
`define MCBT_SZ_1 3'h0
`define MCBT_SZ_2 3'h1
`define MCBT_SZ_4 3'h2
`define MCBT_SZ_8 3'h3
`define MCBT_SZ_16 3'h4

// ----------------------------------------------------------------
// address field positions
// ----------------------------------------------------------------
`define MCBT_LINE_LSB 4
`define MCBT_WORD_LSB 2

`endif

// *** design/mcbt_fifo.sv ***
// read-data fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module mcbt_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32,
  parameter int CW = 6
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CW-1:0] count
);
  typedef struct packed {
    logic [$clog2(DEPTH)-1:0] wp;
    logic [$clog2(DEPTH)-1:0] rp;
    logic [CW-1:0] cnt;
  } mcbt_fifo_s;

  mcbt_fifo_s s_r, s_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  // ----------------------------------------------------------------
  // pointer and level update
  // ----------------------------------------------------------------
  always_comb begin
    push = in_valid && (s_r.cnt != CW'(DEPTH));
    pop = (s_r.cnt != '0) && out_ready;
    s_nxt = s_r;
    if (push) s_nxt.wp = s_r.wp + 1'b1;
    if (pop) s_nxt.rp = s_r.rp + 1'b1;
    s_nxt.cnt = s_r.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge clk) begin
    if (push) mem[s_r.wp] <= in_data;
  end

  assign in_ready = (s_r.cnt != CW'(DEPTH));
  assign out_valid = (s_r.cnt != '0);
  assign out_data = mem[s_r.rp];
  assign count = s_r.cnt;
endmodule
`default_nettype wire

// *** design/mcbt_pkg.sv ***
// types shared by the burst bus sequencer files
package mcbt_pkg;
  typedef enum logic [1:0] {MCBT_IDLE, MCBT_T1, MCBT_T2} mcbt_state_e;
  typedef logic [31:0] mcbt_word_t;
endpackage

// *** tb/mcbt_mem_model.sv ***
// memory-side partner model that answers the burst sequencer's bus cycles
`timescale 1ns/10ps
`default_nettype none
module mcbt_mem_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic addr_strobe_n,
  input wire logic last_transfer_n,
  input wire logic [27:0] line_address_upper,
  input wire logic [1:0] word_addr,
  input wire logic [3:0] waits,
  input wire logic burst,
  input wire logic cont,
  input wire logic both,
  input wire logic ken_n,
  input wire logic bs8_n,
  input wire logic bus_size16_n_n,
  output logic nonburst_ready_n,
  output logic burst_ready_n,
  output logic cache_enable_in_n,
  output logic bus_size8_n,
  output logic bus_size16_n,
  output logic [31:0] data_in
);
  logic act;
  logic [3:0] cnt;
  logic [1:0] piece;
  logic [4:0] shamt;
  logic [31:0] word_v;
  // read data follows the address now on the bus, so a burst item never
  // shows the previous word; without a ready the lines show the inverse
  assign word_v = {line_address_upper[25:0], word_addr, 4'h5};
  assign shamt = !bs8_n ? {piece, 3'h0} : {piece[0], 4'h0};
  assign data_in = (!nonburst_ready_n || !burst_ready_n) ?
                   (word_v >> shamt) : ~word_v;
  // levels are only changed between transfers, so valid well before ready
  assign cache_enable_in_n = ken_n;
  assign bus_size8_n = bs8_n;
  assign bus_size16_n = bus_size16_n_n;
  // ------------------------------------------------------------
  // cycle tracking and ready generation
  // ------------------------------------------------------------
  // low-true handshakes, changed just after the rising edge
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      act = 1'b0;
      cnt = 4'h0;
      nonburst_ready_n <= 1'b1;
      burst_ready_n <= 1'b1;
      piece <= 2'h0;
    end else begin
      // last is only judged at an edge that carries a ready
      if (!nonburst_ready_n || !burst_ready_n) begin
        act = burst && cont && !both && last_transfer_n;
        cnt = waits;
        // narrow buses hand out the word one piece per ready
        piece <= !bs8_n ? piece + 2'h1 : {1'b0, !bus_size16_n_n && !piece[0]};
      end
      // the strobe clock itself never carries a ready
      if (!addr_strobe_n) begin
        act = 1'b1;
        cnt = waits;
      end
      if (act && cnt == 4'h0) begin
        // burst answers hold nonburst high unless both is set; plain areas use nonburst
        nonburst_ready_n <= burst && !both;
        burst_ready_n <= !burst;
        act = 1'b0;
      end else begin
        // wait state: both readies high
        nonburst_ready_n <= 1'b1;
        burst_ready_n <= 1'b1;
        if (act) cnt = cnt - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the multi-cycle burst bus sequencer
`timescale 1ns/10ps
`default_nettype none
`include "mcbt_defines.svh"
module tb;
  import mcbt_pkg::*;
  logic clk, reset_n, req_valid, req_ready, req_write, req_mem, req_data;
  logic req_burstable, req_cacheable, rd_valid, rd_ready, data_oe;
  logic [31:0] req_addr, req_wdata, data_out, data_in, wr_seen, wr_last;
  logic [2:0] req_size;
  mcbt_word_t rd_data;
  logic addr_strobe_n, last_transfer_n, mem_or_io_sel, data_or_code_sel;
  logic write_or_read_sel, nonburst_ready_n, burst_ready_n;
  logic cache_enable_in_n, bus_size8_n, bus_size16_n;
  logic [27:0] line_address_upper;
  logic [1:0] word_addr;
  logic [3:0] byte_lane_enables_n, waits, be_first, be_last;
  logic burst, cont, both, ken_n, bs8_n, bus_size16_n_n, xfer_done;
  int n_mismatch, tests_run, n_strb;
  logic [1:0] ord_q[$];
  logic last_q[$];
  logic [31:0] exp_q[$];

  mcbt_bus_seq dut (.clk, .reset_n, .req_valid, .req_ready, .req_addr,
    .req_size, .req_write, .req_wdata, .req_mem, .req_data, .req_burstable,
    .req_cacheable, .rd_valid, .rd_ready, .rd_data, .addr_strobe_n,
    .last_transfer_n, .line_address_upper, .word_addr, .byte_lane_enables_n,
    .mem_or_io_sel, .data_or_code_sel, .write_or_read_sel, .data_out,
    .data_oe, .data_in, .nonburst_ready_n, .burst_ready_n,
    .cache_enable_in_n, .bus_size8_n, .bus_size16_n);
  mcbt_mem_model mem (.clk, .reset_n, .addr_strobe_n, .last_transfer_n,
    .line_address_upper, .word_addr, .waits, .burst, .cont, .both, .ken_n,
    .bs8_n, .bus_size16_n_n, .nonburst_ready_n, .burst_ready_n, .cache_enable_in_n,
    .bus_size8_n, .bus_size16_n, .data_in);

  // ------------------------------------------------------------
  // compare and closing
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // bus monitor: logs each data cycle end; line and type must hold
  always @(posedge clk) begin
    if (reset_n && !addr_strobe_n) n_strb++;
    if (reset_n && (!nonburst_ready_n || !burst_ready_n)) begin
      ord_q.push_back(word_addr);
      last_q.push_back(last_transfer_n);
      if (ord_q.size() == 1) wr_seen = data_out;
      if (ord_q.size() == 1) be_first = byte_lane_enables_n;
      wr_last = data_out;
      be_last = byte_lane_enables_n;
      chk("line", 32'(req_addr[31:4]), 32'(line_address_upper));
      chk("mem_io", 32'(req_mem), 32'(mem_or_io_sel));
      chk("dat_code", 32'(req_data), 32'(data_or_code_sel));
      chk("wr_rd", 32'(req_write), 32'(write_or_read_sel));
      chk("oe", 32'(req_write), 32'(data_oe));
      if (!last_transfer_n) xfer_done = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------
  task automatic cfg(input logic [3:0] w, input logic b, input logic c,
                     input logic bo, input logic k);
    @(negedge clk);
    waits = w;
    burst = b;
    cont = c;
    both = bo;
    ken_n = k;
  endtask

  // one request; word i of the transfer is expected at first word xor i
  task automatic run(input logic [31:0] a, input logic [2:0] sz,
                     input logic wr, input logic ca, input logic bu,
                     input int nr, input int ns, input int ppw);
    int i;
    ord_q.delete();
    last_q.delete();
    @(negedge clk);
    n_strb = 0;
    xfer_done = 1'b0;
    req_addr = a;
    req_size = sz;
    req_write = wr;
    req_cacheable = ca;
    req_burstable = bu;
    req_wdata = 32'h3c5a96e1 ^ a;
    req_valid = 1'b1;
    i = 0;
    while (req_ready !== 1'b1 && i < 60) begin
      @(negedge clk);
      i++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    i = 0;
    while (!xfer_done && i < 100) begin
      @(negedge clk);
      i++;
    end
    repeat (3) @(negedge clk);
    chk("readies", nr, ord_q.size());
    chk("strobes", ns, n_strb);
    foreach (ord_q[j]) begin
      chk("word", 32'(a[3:2] ^ 2'(j / ppw)), 32'(ord_q[j]));
      chk("last", 32'(j != nr - 1), 32'(last_q[j]));
    end
    if (wr) chk("wdata", req_wdata, wr_seen);
    if (wr) chk("wlast", req_wdata >> (32 - 32 / ppw), wr_last);
    if (!wr) begin
      for (i = 0; i < nr / ppw; i++) begin
        exp_q.push_back({a[29:4], a[3:2] ^ 2'(i), 4'h5});
      end
    end
  endtask

  // the far side has stalled until now; empty the fifo and compare
  task automatic drain();
    int i;
    @(negedge clk);
    rd_ready = 1'b1;
    while (exp_q.size() > 0) begin
      i = 0;
      while (rd_valid !== 1'b1 && i < 20) begin
        @(negedge clk);
        i++;
      end
      chk("rdata", exp_q.pop_front(), rd_data);
      @(negedge clk);
    end
    rd_ready = 1'b0;
    chk("empty", 0, rd_valid);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_burst8();
    cfg(4'h0, 1, 1, 0, 1);
    run(32'h1008, `MCBT_SZ_8, 0, 0, 1, 2, 1, 1);
    drain();
  endtask

  task automatic t_nb_wait();
    cfg(4'h2, 0, 0, 0, 1);
    run(32'h2008, `MCBT_SZ_8, 0, 0, 1, 2, 2, 1);
    drain();
  endtask

  task automatic t_fill();
    cfg(4'h0, 1, 1, 0, 0);
    for (int k = 0; k < 4; k++) begin
      run(32'h3100 + 4 * k, `MCBT_SZ_4, 0, 1, 1, 4, 1, 1);
    end
    cfg(4'h0, 1, 1, 0, 1);
    run(32'h3104, `MCBT_SZ_4, 0, 1, 1, 1, 1, 1);
    drain();
  endtask

  task automatic t_both();
    cfg(4'h1, 1, 1, 1, 0);
    run(32'h4104, `MCBT_SZ_4, 0, 1, 1, 4, 4, 1);
    drain();
  endtask

  task automatic t_nobrst();
    cfg(4'h0, 1, 0, 0, 1);
    run(32'h5008, `MCBT_SZ_8, 0, 0, 0, 2, 2, 1);
    drain();
    run(32'h5020, `MCBT_SZ_4, 1, 0, 1, 1, 1, 1);
  endtask

  task automatic t_narrow();
    cfg(4'h0, 1, 1, 0, 1);
    bus_size16_n_n = 1'b0;
    run(32'h6010, `MCBT_SZ_4, 1, 0, 1, 2, 1, 2);
    bus_size16_n_n = 1'b1;
    bs8_n = 1'b0;
    run(32'h6030, `MCBT_SZ_4, 0, 0, 1, 4, 1, 4);
    bs8_n = 1'b1;
    drain();
  endtask

  task automatic t_unal();
    cfg(4'h0, 1, 1, 0, 1);
    run(32'h7042, `MCBT_SZ_4, 0, 0, 1, 2, 1, 1);
    chk("be_first", 32'h3, 32'(be_first));
    chk("be_last", 32'hc, 32'(be_last));
    drain();
  endtask

  task automatic t_full();
    cfg(4'h0, 1, 1, 0, 1);
    for (int k = 0; k < 8; k++) begin
      run(32'h8000 + 16 * k, `MCBT_SZ_16, 0, 0, 1, 4, 1, 1);
    end
    chk("room", 0, req_ready);
    drain();
  endtask

  // ------------------------------------------------------------
  // clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // far longer than the whole sequence needs
  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    reset_n = 1'b0;
    {req_valid, req_write, req_burstable, req_cacheable, rd_ready} = '0;
    {req_mem, req_data, bs8_n, bus_size16_n_n, ken_n} = '1;
    {burst, cont, both} = '0;
    waits = 4'h0;
    req_addr = 32'h0;
    req_wdata = 32'h0;
    req_size = 3'h0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk("rst_strobe", 1, addr_strobe_n);
    chk("rst_be", 32'hf, byte_lane_enables_n);
    chk("rst_oe", 0, data_oe);
    reset_n = 1'b1;
    t_burst8();
    t_nb_wait();
    t_fill();
    t_both();
    t_nobrst();
    t_narrow();
    t_unal();
    t_full();
    end_sim();
  end
endmodule
`default_nettype wire
